// >>> tb/bulk_ctl_model.sv
// behavioural bulk store controller: accepts a record, streams words to record end
// assumes one request at a time; words one every 100 ns
`timescale 1ns/1ns
module bulk_ctl_model #(
   parameter int LAT = 3
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_req,
   input wire logic [23:0] i_addr,
   output logic o_accept,
   output logic o_word
);
   int n;
   initial begin
      o_accept = 1'b0;
      o_word = 1'b0;
      forever begin
         @(posedge i_clk_sys);
         if (i_rst_n && i_req === 1'b1) begin
            n = 8 - int'(i_addr[2:0]);
            repeat (LAT) @(posedge i_clk_sys);
            o_accept <= i_req;
            while (i_req === 1'b1) @(posedge i_clk_sys);
            o_accept <= 1'b0;
            repeat (n) begin
               repeat (9) @(posedge i_clk_sys);
               o_word <= 1'b1;
               @(posedge i_clk_sys);
               o_word <= 1'b0;
            end
         end
      end
   end
endmodule // bulk_ctl_model

// >>> tb/bulk_xfer_seq_properties.sv
// concurrent checks on the sequencer top ports
// assumes bind into bulk_xfer_seq, one clock domain
`timescale 1ns/1ns
module bulk_xfer_seq_properties #(
   parameter int AW = 24
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_swap,
   input wire logic i_pp_break,
   input wire logic i_ctl_accept,
   input wire logic i_ctl_word,
   input wire logic i_ctl_abort,
   input wire logic i_ctl_parity_err,
   input wire logic o_ctl_req,
   input wire logic [AW-1:0] o_ctl_addr,
   input wire logic o_word_take,
   input wire logic o_busy,
   input wire logic o_end_op,
   input wire logic o_bounds_err,
   input wire logic o_abort,
   input wire logic o_parity_err
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   AST_ABORT_RELAY: assert property (i_ctl_abort |=> o_abort)
      else $error("abort not relayed");
   AST_PARITY_RELAY: assert property (i_ctl_parity_err |=> o_parity_err)
      else $error("parity error not relayed");
   AST_REQ_HOLD: assert property (o_ctl_req && !i_ctl_accept && !i_swap && !i_pp_break |=> o_ctl_req)
      else $error("request dropped before accept");
   AST_ADDR_STABLE: assert property (o_ctl_req && !i_ctl_accept && !i_swap |=> $stable(o_ctl_addr))
      else $error("controller address moved while waiting");
   AST_IDLE_NOREQ: assert property (!o_busy |-> !o_ctl_req)
      else $error("request while idle");
   AST_TAKE_CAUSE: assert property (o_word_take |-> $past(i_ctl_word))
      else $error("word taken without a streamed word");
   AST_END_PULSE: assert property ($rose(o_end_op) |=> !o_end_op)
      else $error("end of operation longer than one cycle");
   AST_ERR_NOREQ: assert property (o_bounds_err |-> !o_ctl_req)
      else $error("request after bounds failure");
endmodule // bulk_xfer_seq_properties
bind bulk_xfer_seq bulk_xfer_seq_properties #(.AW(AW)) u_props (.*);

// >>> tb/bulk_xfer_seq_tb.sv
// self-checking bench of the bulk store block transfer sequencer
// assumes the controller model on the far side
`timescale 1ns/1ns
`include "bulk_xfer_consts.svh"
module bulk_xfer_seq_tb;
   logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_start = 1'b0, i_store = 1'b0;
   logic i_swap_load = 1'b0, i_swap = 1'b0, i_pp_break = 1'b0, i_pp_resume = 1'b0;
   logic i_ctl_abort = 1'b0, i_ctl_parity_err = 1'b0, i_ctl_accept, i_ctl_word;
   logic [23:0] fp = 24'h0, np = 24'h0, cnt = 24'h0, o_ctl_addr, o_mem_addr, a1, a2, m1;
   logic o_ctl_req, o_ctl_store, o_word_take, o_busy, o_end_op, o_bounds_err, o_abort, o_parity_err, s1;
   int n_mismatch = 0, comparisons = 0, n_take = 0, n_end = 0, n_req = 0;
   always #5 i_clk_sys = ~i_clk_sys;
   bulk_xfer_seq u_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_start(i_start), .i_store(i_store),
      .i_far_pointer_staging(fp), .i_near_pointer_staging(np), .i_count_staging(cnt),
      .i_swap_load(i_swap_load), .i_near_bounds_length(24'h000100), .i_far_bounds_length(24'h000100),
      .i_near_relocation_base(24'h001000), .i_far_relocation_base(24'h002000), .i_swap(i_swap),
      .i_pp_break(i_pp_break), .i_pp_resume(i_pp_resume), .i_ctl_accept(i_ctl_accept),
      .i_ctl_word(i_ctl_word), .i_ctl_abort(i_ctl_abort), .i_ctl_parity_err(i_ctl_parity_err),
      .o_ctl_req(o_ctl_req), .o_ctl_store(o_ctl_store), .o_ctl_addr(o_ctl_addr),
      .o_word_take(o_word_take), .o_mem_addr(o_mem_addr), .o_busy(o_busy), .o_end_op(o_end_op),
      .o_bounds_err(o_bounds_err), .o_abort(o_abort), .o_parity_err(o_parity_err));
   bulk_ctl_model u_ctl (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(o_ctl_req), .i_addr(o_ctl_addr),
      .o_accept(i_ctl_accept), .o_word(i_ctl_word));
   always @(posedge i_clk_sys) begin
      if (o_word_take === 1'b1 && n_take == 0) m1 <= o_mem_addr;
      if (o_word_take === 1'b1) n_take <= n_take + 1;
      if (o_end_op === 1'b1) n_end <= n_end + 1;
      if (o_ctl_req === 1'b1 && n_req == 0) {a1, s1} <= {o_ctl_addr, o_ctl_store};
      if (o_ctl_req === 1'b1) n_req <= n_req + 1;
      if (o_ctl_req === 1'b1) a2 <= o_ctl_addr;
   end
   task automatic chk(input logic [23:0] e, input logic [23:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic wait_busy(input logic v);
      int k;
      for (k = 0; k < 4000 && o_busy !== v; k++) @(posedge i_clk_sys);
      chk(v, o_busy);
   endtask
   // one whole transfer from idle to idle
   task automatic xfer(input logic [23:0] f, input logic [23:0] c, input logic st);
      @(posedge i_clk_sys);
      {n_take, n_end, n_req} <= '0;
      fp <= f;
      np <= 24'h000020;
      cnt <= c;
      i_store <= st;
      i_start <= 1'b1;
      wait_busy(1'b1);
      @(posedge i_clk_sys);
      i_start <= 1'b0;
      wait_busy(1'b0);
      repeat (3) @(posedge i_clk_sys);
   endtask
   task automatic t_multi;
      fork
         xfer(24'h000013, 24'h000014, 1'b0);
         begin
            wait (n_take >= 6);
            @(posedge i_clk_sys);
            i_pp_break <= 1'b1;
            // break-in is admitted at the request of the third record
            wait (n_take >= 13);
            repeat (20) @(posedge i_clk_sys);
            chk(1'b0, o_ctl_req);
            chk(1'b1, o_busy);
            i_pp_resume <= 1'b1;
            @(posedge i_clk_sys);
            {i_pp_resume, i_pp_break} <= 2'b00;
         end
      join
      chk(24'h000014, 24'(n_take));
      chk(24'h002013, a1);
      chk(24'h001020, m1);
      chk(24'h001033, o_mem_addr);
      chk(24'h002020, a2);
      chk(24'h1, 24'(n_end));
      chk(1'b0, o_bounds_err);
      $display("test multi record done");
   endtask
   task automatic t_single;
      xfer(24'h000023, 24'h000001, 1'b1);
      chk(24'h1, 24'(n_take));
      chk(1'b1, s1);
      chk(24'h1, 24'(n_end));
      $display("test single word done");
   endtask
   task automatic t_bounds;
      xfer(24'h0000F8, 24'h000010, 1'b0);
      chk(1'b1, o_bounds_err);
      chk(24'h0, 24'(n_req));
      $display("test bounds done");
   endtask
   task automatic t_swap;
      fork
         xfer(24'h000000, 24'h000018, 1'b0);
         begin
            wait (n_take >= 2);
            @(posedge i_clk_sys);
            i_swap <= 1'b1;
            @(posedge i_clk_sys);
            i_swap <= 1'b0;
         end
      join
      chk(24'h0, 24'(n_end));
      @(posedge i_clk_sys);
      {i_ctl_abort, i_ctl_parity_err} <= 2'b11;
      @(posedge i_clk_sys);
      {i_ctl_abort, i_ctl_parity_err} <= 2'b00;
      #1;
      chk(2'b11, {o_abort, o_parity_err});
      $display("test swap and relay done");
   endtask
   task automatic stop_test;
      $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      @(posedge i_clk_sys);
      chk(4'h0, {o_ctl_req, o_busy, o_end_op, o_bounds_err});
      i_swap_load <= 1'b1;
      @(posedge i_clk_sys);
      i_swap_load <= 1'b0;
      t_multi();
      t_single();
      t_bounds();
      t_swap();
      stop_test();
   end
   // sized well above the four transfers, 60000 cycles
   initial begin
      repeat (60000) @(posedge i_clk_sys);
      n_mismatch++;
      stop_test();
   end
endmodule // bulk_xfer_seq_tb

// >>> verilog/bulk_xfer_consts.svh
// shared constants of the bulk store block transfer sequencer
// assumes inclusion by bare name from design and bench files
`ifndef BULK_XFER_CONSTS_SVH
`define BULK_XFER_CONSTS_SVH
`define ADDR_W 24
`define REC_WORDS 24'h000008
`define LOW_MASK 24'h000007
`define CLK_PERIOD_NS 10
`define STEP_HOLD_NS 100
`define STEP_GAP_NS 50
`define STEP_HOLD_CYC ((`STEP_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_GAP_CYC (`STEP_GAP_NS / `CLK_PERIOD_NS)
`define SETUP_STEPS 5'h1A
`endif

// >>> verilog/bulk_xfer_pkg.sv
// types of the bulk store block transfer sequencer
// assumes the constants header is compiled alongside
package bulk_xfer_pkg;
   typedef enum logic [10:0] {
      ST_IDLE    = 11'h001,
      ST_CHK_NEAR = 11'h002,
      ST_CHK_FAR = 11'h004,
      ST_RELOC   = 11'h008,
      ST_RCOUNT  = 11'h010,
      ST_COMPARE = 11'h020,
      ST_TALLY   = 11'h040,
      ST_REQ     = 11'h080,
      ST_ADV     = 11'h100,
      ST_NEARREL = 11'h200,
      ST_HOLD    = 11'h400
   } seq_state_t;
endpackage

// >>> verilog/bulk_xfer_seq.sv
// top of the bulk store block transfer sequencer
// assumes the controller streams words from the start word to the record end
`timescale 1ns/1ns
`include "bulk_xfer_consts.svh"
module bulk_xfer_seq
   import bulk_xfer_pkg::*;
#(
   parameter int AW = `ADDR_W
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic i_store,
   input wire logic [AW-1:0] i_far_pointer_staging,
   input wire logic [AW-1:0] i_near_pointer_staging,
   input wire logic [AW-1:0] i_count_staging,
   input wire logic i_swap_load,
   input wire logic [AW-1:0] i_near_bounds_length,
   input wire logic [AW-1:0] i_far_bounds_length,
   input wire logic [AW-1:0] i_near_relocation_base,
   input wire logic [AW-1:0] i_far_relocation_base,
   input wire logic i_swap,
   input wire logic i_pp_break,
   input wire logic i_pp_resume,
   input wire logic i_ctl_accept,
   input wire logic i_ctl_word,
   input wire logic i_ctl_abort,
   input wire logic i_ctl_parity_err,
   output logic o_ctl_req,
   output logic o_ctl_store,
   output logic [AW-1:0] o_ctl_addr,
   output logic o_word_take,
   output logic [AW-1:0] o_mem_addr,
   output logic o_busy,
   output logic o_end_op,
   output logic o_bounds_err,
   output logic o_abort,
   output logic o_parity_err
);
   seq_state_t state_r;
   logic [AW-1:0] near_len_r, far_len_r, near_base_r, far_base_r;
   logic [AW-1:0] far_r, near_r, tally_r, rcount_r, mem_next_r;
   logic [AW-1:0] add_a, add_b;
   logic add_sub;
   logic [AW-1:0] add_y;
   logic [2:0] down_r;
   logic down_en_r, down_last_r, last_r, first_r, broke_r, store_r;
   logic [3:0] skip_r;
   logic step, step_active;
   logic pipe_free;

   function automatic logic is_running(input seq_state_t s);
      is_running = s != ST_IDLE;
   endfunction

   step_pacer #(
      .HOLD_CYC(`STEP_HOLD_CYC),
      .GAP_CYC(`STEP_GAP_CYC)
   ) u_pacer (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_run((is_running(state_r) || i_start) && state_r != ST_HOLD),
      .o_step(step),
      .o_active(step_active)
   );

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         near_len_r <= '0;
         far_len_r <= '0;
         near_base_r <= '0;
         far_base_r <= '0;
      end else if (i_swap_load && !is_running(state_r)) begin
         near_len_r <= i_near_bounds_length;
         far_len_r <= i_far_bounds_length;
         near_base_r <= i_near_relocation_base;
         far_base_r <= i_far_relocation_base;
      end
   end

   // single shared adder, operands chosen per step
   always_comb begin
      add_a = '0;
      add_b = '0;
      add_sub = 1'b0;
      case (state_r)
         ST_CHK_NEAR: begin
            add_a = near_len_r;
            add_b = near_r + tally_r;
            add_sub = 1'b1;
         end
         ST_CHK_FAR: begin
            add_a = far_len_r;
            add_b = far_r + tally_r;
            add_sub = 1'b1;
         end
         ST_RELOC: begin
            add_a = far_r;
            add_b = far_base_r;
         end
         ST_RCOUNT: begin
            add_a = `REC_WORDS;
            add_b = first_r ? (far_r & `LOW_MASK) : '0;
            add_sub = 1'b1;
         end
         ST_COMPARE: begin
            add_a = rcount_r;
            add_b = tally_r;
            add_sub = 1'b1;
         end
         ST_TALLY: begin
            add_a = tally_r;
            add_b = rcount_r;
            add_sub = 1'b1;
         end
         ST_ADV: begin
            add_a = far_r;
            add_b = rcount_r;
         end
         ST_NEARREL: begin
            add_a = near_r;
            add_b = near_base_r;
         end
         default: begin
            add_a = '0;
            add_b = '0;
         end
      endcase
   end
   assign add_y = add_sub ? add_a - add_b : add_a + add_b;

   // setup of a new record waits until the record in flight has taken its last word, unless that record is the last of its transfer
   assign pipe_free = !down_en_r || down_last_r;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= ST_IDLE;
         far_r <= '0;
         near_r <= '0;
         tally_r <= '0;
         rcount_r <= '0;
         last_r <= 1'b0;
         first_r <= 1'b0;
         broke_r <= 1'b0;
         store_r <= 1'b0;
         o_bounds_err <= 1'b0;
      end else if (i_swap) begin
         state_r <= ST_IDLE;
         last_r <= 1'b0;
      end else if (step) begin
         case (state_r)
            ST_IDLE: begin
               if (i_start) begin
                  far_r <= i_far_pointer_staging;
                  near_r <= i_near_pointer_staging;
                  tally_r <= i_count_staging;
                  store_r <= i_store;
                  first_r <= 1'b1;
                  broke_r <= 1'b0;
                  o_bounds_err <= 1'b0;
                  state_r <= ST_CHK_NEAR;
               end
            end
            ST_CHK_NEAR: begin
               if (add_y[AW-1]) begin
                  o_bounds_err <= 1'b1;
                  state_r <= ST_IDLE;
               end else begin
                  state_r <= ST_CHK_FAR;
               end
            end
            ST_CHK_FAR: begin
               if (add_y[AW-1]) begin
                  o_bounds_err <= 1'b1;
                  state_r <= ST_IDLE;
               end else begin
                  state_r <= ST_RELOC;
               end
            end
            ST_RELOC: begin
               far_r <= add_y;
               state_r <= ST_RCOUNT;
            end
            ST_RCOUNT: begin
               rcount_r <= add_y;
               state_r <= ST_COMPARE;
            end
            ST_COMPARE: begin
               if (!add_y[AW-1]) begin
                  rcount_r <= tally_r;
                  last_r <= 1'b1;
               end
               state_r <= ST_TALLY;
            end
            ST_TALLY: begin
               if (pipe_free) begin
                  tally_r <= add_y;
                  state_r <= ST_REQ;
               end
            end
            ST_REQ: begin
               if (i_pp_break && !broke_r && !first_r) begin
                  broke_r <= 1'b1;
                  state_r <= ST_HOLD;
               end else if (i_ctl_accept && pipe_free) begin
                  state_r <= ST_ADV;
               end
            end
            ST_ADV: begin
               far_r <= add_y;
               state_r <= first_r ? ST_NEARREL : ST_RCOUNT;
               first_r <= 1'b0;
               broke_r <= 1'b0;
               // no more setup after the last record
               if (last_r) begin
                  state_r <= first_r ? ST_NEARREL : ST_IDLE;
               end
            end
            ST_NEARREL: begin
               near_r <= add_y;
               state_r <= last_r ? ST_IDLE : ST_RCOUNT;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end else if (state_r == ST_HOLD && i_pp_resume) begin
         state_r <= ST_REQ;
      end
      if (state_r == ST_IDLE && last_r && !down_en_r) begin
         last_r <= 1'b0;
      end
   end

   assign o_ctl_req = state_r == ST_REQ && !i_pp_break;
   assign o_ctl_store = store_r;
   assign o_ctl_addr = far_r;
   assign o_busy = is_running(state_r) || down_en_r || step_active;

   // downcounter runs while the next record is set up
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         down_r <= 3'h0;
         down_en_r <= 1'b0;
         down_last_r <= 1'b0;
         skip_r <= 4'h0;
         o_mem_addr <= '0;
         mem_next_r <= '0;
         o_word_take <= 1'b0;
         o_end_op <= 1'b0;
      end else begin
         o_word_take <= 1'b0;
         o_end_op <= 1'b0;
         if (i_swap) begin
            down_en_r <= 1'b0;
            skip_r <= 4'h0;
         end else if (step && state_r == ST_ADV) begin
            down_r <= 3'(rcount_r - 24'h000001);
            down_en_r <= rcount_r != '0;
            down_last_r <= last_r;
            skip_r <= 4'(`REC_WORDS - rcount_r - (first_r ? (far_r & `LOW_MASK) : '0));
            if (rcount_r == '0 && last_r) begin
               o_end_op <= 1'b1;
            end
         end else if (i_ctl_word) begin
            if (down_en_r) begin
               o_word_take <= 1'b1;
               o_mem_addr <= mem_next_r;
               mem_next_r <= mem_next_r + 24'h000001;
               down_r <= down_r - 3'h1;
               if (down_r == 3'h0) begin
                  down_en_r <= 1'b0;
                  o_end_op <= down_last_r;
               end
            end else if (skip_r != 4'h0) begin
               skip_r <= skip_r - 4'h1;
            end
         end
         if (step && state_r == ST_NEARREL) begin
            mem_next_r <= add_y;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_abort <= 1'b0;
         o_parity_err <= 1'b0;
      end else begin
         o_abort <= i_ctl_abort;
         o_parity_err <= i_ctl_parity_err;
      end
   end
endmodule // bulk_xfer_seq

// >>> verilog/step_pacer.sv
// step pacer: each step held a fixed time, successive steps a fixed gap apart
// assumes one clock domain and a run level held high by the sequencer
`timescale 1ns/1ns
`include "bulk_xfer_consts.svh"
module step_pacer #(
   parameter int HOLD_CYC = `STEP_HOLD_CYC,
   parameter int GAP_CYC = `STEP_GAP_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_run,
   output logic o_step,
   output logic o_active
);
   logic [7:0] gap_r;
   logic [7:0] hold_r;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gap_r <= 8'h00;
      end else if (!i_run || gap_r == 8'(GAP_CYC - 1)) begin
         gap_r <= 8'h00;
      end else begin
         gap_r <= gap_r + 8'h01;
      end
   end
   assign o_step = i_run && gap_r == 8'(GAP_CYC - 1);
   // a step flag stays up for the hold time though the next one starts earlier
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hold_r <= 8'h00;
      end else if (o_step) begin
         hold_r <= 8'(HOLD_CYC);
      end else if (hold_r != 8'h00) begin
         hold_r <= hold_r - 8'h01;
      end
   end
   assign o_active = hold_r != 8'h00;
endmodule // step_pacer
